// [rtl/ddf_top.sv]
// Dedisperse, detect and fold/integrate engine for one sub-band beam, APB register slave.
// Assumes samples synchronous to SYS_CLK and a single-channel dual-pol stream.
// What this block does
// - I=|X|^2+|Y|^2, Q=|X|^2-|Y|^2, U=2Re(X conj Y), V=-2Im(X conj Y).
// - Pulsar mode: periods 1 ms to 30 s, up to 2048 phase bins.
// - Each sample's arrival time gives a phase from the model, mapped to a bin.
// - Add four Stokes values into the selected bin, increment its counter.
// - At integration end, output all bins and counters, then zero them.
// - Transient mode skips folding, integrates to the set time resolution.
// - Both modes share processing; only the integration step differs.
// - Dedisperse by FFT, kernel (optional window), inverse FFT, keep centre samples.
// - FFT length is at least the number of discarded samples.
// - One kernel length and FFT length for every channel of the sub-band.
// - Software sets DM and window; kernel recomputed only when they change.
`timescale 1ns/1ps
`include "ddf_cfg.svh"
module ddf_top (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IN_VALID,
  input wire logic [7:0] IN_X_RE,
  input wire logic [7:0] IN_X_IM,
  input wire logic [7:0] IN_Y_RE,
  input wire logic [7:0] IN_Y_IM,
  output logic IN_READY,
  output logic OUT_VALID,
  output logic OUT_LAST,
  output logic [`DDF_BIN_W-1:0] OUT_BIN,
  output logic [31:0] OUT_I,
  output logic [31:0] OUT_Q,
  output logic [31:0] OUT_U,
  output logic [31:0] OUT_V,
  output logic [15:0] OUT_COUNT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  ddf_pkg::ddf_state_e state_ff;
  logic [2:0] ctrl_ff;
  logic [15:0] dm_ff, tres_ff, tcnt_ff;
  logic [11:0] nbins_ff;
  logic [31:0] accel_ff, intlen_ff, intcnt_ff, phase_ff, step_ff;
  logic [31:0] fq0_ff, fq1_ff;
  logic [1:0] fcnt_ff, nxt_fcnt;
  logic push, pop, wr_hi, wr_en, apb_hit;
  logic [31:0] rd_val;

  // APB: one wait state, so PREADY and PRDATA come from flops
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  always_comb begin
    apb_hit = 1'b1;
    rd_val = 32'h0;
    case (PADDR)
      `DDF_A_CTRL: rd_val = {29'h0, ctrl_ff};
      `DDF_A_DM: rd_val = {16'h0, dm_ff};
      `DDF_A_NBINS: rd_val = {20'h0, nbins_ff};
      `DDF_A_STEP: rd_val = step_ff;
      `DDF_A_ACCEL: rd_val = accel_ff;
      `DDF_A_INTLEN: rd_val = intlen_ff;
      `DDF_A_TRES: rd_val = {16'h0, tres_ff};
      `DDF_A_STATUS: rd_val = {27'h0, fcnt_ff, state_ff};
      `DDF_A_INTCNT: rd_val = intcnt_ff;
      default: apb_hit = 1'b0;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PRDATA <= (PSEL && !PWRITE) ? rd_val : 32'h0;
      PSLVERR <= PSEL && PENABLE && !PREADY && !apb_hit;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_ff <= `DDF_RST_CTRL;
      dm_ff <= 16'h0;
      nbins_ff <= `DDF_RST_NBINS;
      accel_ff <= 32'h0;
      intlen_ff <= 32'h0;
      tres_ff <= `DDF_RST_TRES;
    end else if (wr_en) begin
      case (PADDR)
        `DDF_A_CTRL: ctrl_ff <= PWDATA[2:0];
        `DDF_A_DM: dm_ff <= PWDATA[15:0];
        `DDF_A_NBINS: nbins_ff <= PWDATA[11:0];
        `DDF_A_ACCEL: accel_ff <= PWDATA;
        `DDF_A_INTLEN: intlen_ff <= PWDATA;
        `DDF_A_TRES: tres_ff <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Two-entry input buffer; a stall during readout fills it and drops IN_READY
  logic take;
  assign take = (fcnt_ff != 2'd0) && (state_ff == ddf_pkg::S_COLLECT) && ctrl_ff[`DDF_CTRL_EN];
  assign push = IN_VALID && IN_READY;
  assign pop = take;
  assign nxt_fcnt = 2'(fcnt_ff + {1'b0, push} - {1'b0, pop});
  assign wr_hi = (fcnt_ff == 2'd2) || ((fcnt_ff == 2'd1) && !pop);
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fcnt_ff <= 2'd0;
      IN_READY <= 1'b1;
      fq0_ff <= 32'h0;
      fq1_ff <= 32'h0;
    end else begin
      fcnt_ff <= nxt_fcnt;
      IN_READY <= nxt_fcnt != 2'd2;
      if (pop) begin
        fq0_ff <= fq1_ff;
      end
      if (push && wr_hi) begin
        fq1_ff <= {IN_X_RE, IN_X_IM, IN_Y_RE, IN_Y_IM};
      end else if (push) begin
        fq0_ff <= {IN_X_RE, IN_X_IM, IN_Y_RE, IN_Y_IM};
      end
    end
  end

  // Kernel: quarter-turn chirp phase per bin plus optional window, cached per config
  logic [15:0] kdm_ff;
  logic kwin_ff;
  logic [1:0] krot_ff [0:3];
  logic [1:0] nxt_rot [0:3];
  logic kern_stale;
  assign kern_stale = (kdm_ff != dm_ff) || (kwin_ff != ctrl_ff[`DDF_CTRL_WIN]);
  for (genvar k = 0; k < `DDF_FFT_LEN; k++) begin : g_kern
    assign nxt_rot[k] = 2'(dm_ff * 16'(k * k));
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        krot_ff[k] <= 2'd0;
      end else if (kern_stale) begin
        krot_ff[k] <= nxt_rot[k];
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      kdm_ff <= 16'h0;
      kwin_ff <= 1'b0;
    end else if (kern_stale) begin
      kdm_ff <= dm_ff;
      kwin_ff <= ctrl_ff[`DDF_CTRL_WIN];
    end
  end

  function automatic ddf_pkg::ddf_cx_s mulj(input ddf_pkg::ddf_cx_s c);
    mulj.re = -c.im;
    mulj.im = c.re;
  endfunction
  function automatic ddf_pkg::ddf_cx4_t fft4(input ddf_pkg::ddf_cx4_t v, input logic inv);
    ddf_pkg::ddf_cx_s s02, d02, s13, jd;
    s02 = '{v[0].re + v[2].re, v[0].im + v[2].im};
    d02 = '{v[0].re - v[2].re, v[0].im - v[2].im};
    s13 = '{v[1].re + v[3].re, v[1].im + v[3].im};
    jd = mulj('{v[1].re - v[3].re, v[1].im - v[3].im});
    if (inv) begin
      jd = '{-jd.re, -jd.im};
    end
    fft4[0] = '{s02.re + s13.re, s02.im + s13.im};
    fft4[2] = '{s02.re - s13.re, s02.im - s13.im};
    fft4[1] = '{d02.re - jd.re, d02.im - jd.im};
    fft4[3] = '{d02.re + jd.re, d02.im + jd.im};
  endfunction
  function automatic ddf_pkg::ddf_cx_s kern(input ddf_pkg::ddf_cx_s c, input logic [1:0] r, input logic half);
    ddf_pkg::ddf_cx_s t;
    case (r)
      2'd1: t = mulj(c);
      2'd2: t = '{-c.re, -c.im};
      2'd3: t = '{c.im, -c.re};
      default: t = c;
    endcase
    kern = t;
    if (half) begin
      kern = '{t.re >>> 1, t.im >>> 1};
    end
  endfunction

  // Overlap-save: 4-point window advances by 2; edge samples are discarded
  ddf_pkg::ddf_cx4_t wx_ff, wy_ff, gx, gy, tx, ty;
  always_comb begin
    ddf_pkg::ddf_cx4_t fx, fy;
    fx = fft4(wx_ff, 1'b0);
    fy = fft4(wy_ff, 1'b0);
    for (int k = 0; k < `DDF_FFT_LEN; k++) begin
      gx[k] = kern(fx[k], krot_ff[k], kwin_ff && (k == 2));
      gy[k] = kern(fy[k], krot_ff[k], kwin_ff && (k == 2));
    end
    tx = fft4(gx, 1'b1);
    ty = fft4(gy, 1'b1);
  end

  logic signed [11:0] dd_ff [0:1][0:3];
  logic sel_ff, new_ff, pend_ff;
  logic signed [11:0] xr, xi, yr, yi;
  logic signed [24:0] px, py, cr, ci;
  logic signed [31:0] st_i, st_q, st_u, st_v;
  logic [31:0] stk_ff [0:3];
  logic [`DDF_BIN_W-1:0] bin, bin_ff, dbin_ff, slot_ff;
  logic [43:0] prod;
  logic [`DDF_ENTRY_W-1:0] mem_rd, mem_wd, acc_rd;
  logic [`DDF_MAX_BINS-1:0] bval_ff;
  logic bval_rd_ff;
  logic mem_we, last_bin;
  logic [`DDF_BIN_W-1:0] mem_wa, mem_ra;
  logic [31:0] nxt_int;

  assign xr = dd_ff[sel_ff][0];
  assign xi = dd_ff[sel_ff][1];
  assign yr = dd_ff[sel_ff][2];
  assign yi = dd_ff[sel_ff][3];
  assign px = 25'(xr * xr) + 25'(xi * xi);
  assign py = 25'(yr * yr) + 25'(yi * yi);
  assign cr = 25'(xr * yr) + 25'(xi * yi);
  assign ci = 25'(xi * yr) - 25'(xr * yi);
  assign st_i = 32'(px) + 32'(py);
  assign st_q = 32'(px) - 32'(py);
  assign st_u = 32'(cr) <<< 1;
  assign st_v = -(32'(ci) <<< 1);
  assign prod = 44'(phase_ff) * 44'(nbins_ff);
  assign bin = ctrl_ff[`DDF_CTRL_MODE] ? slot_ff : prod[42:32];
  assign last_bin = dbin_ff == 11'(nbins_ff - 12'h001);
  assign nxt_int = intcnt_ff + 32'h1;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_ff <= ddf_pkg::S_COLLECT;
      wx_ff <= '0;
      wy_ff <= '0;
      dd_ff <= '{default: '0};
      stk_ff <= '{default: '0};
      sel_ff <= 1'b0;
      new_ff <= 1'b0;
      pend_ff <= 1'b0;
      bin_ff <= '0;
      dbin_ff <= '0;
      intcnt_ff <= 32'h0;
    end else begin
      case (state_ff)
        ddf_pkg::S_COLLECT: begin
          if (take) begin
            wx_ff <= {18'(signed'(fq0_ff[31:24])), 18'(signed'(fq0_ff[23:16])), wx_ff[3:1]};
            wy_ff <= {18'(signed'(fq0_ff[15:8])), 18'(signed'(fq0_ff[7:0])), wy_ff[3:1]};
            new_ff <= !new_ff;
            if (new_ff) begin
              state_ff <= ddf_pkg::S_BLOCK;
            end
          end
        end
        ddf_pkg::S_BLOCK: begin
          for (int s = 0; s < `DDF_DISCARD; s++) begin
            dd_ff[s][0] <= 12'(tx[s + 1].re >>> 2);
            dd_ff[s][1] <= 12'(tx[s + 1].im >>> 2);
            dd_ff[s][2] <= 12'(ty[s + 1].re >>> 2);
            dd_ff[s][3] <= 12'(ty[s + 1].im >>> 2);
          end
          sel_ff <= 1'b0;
          state_ff <= ddf_pkg::S_READ;
        end
        ddf_pkg::S_READ: begin
          stk_ff <= '{st_i, st_q, st_u, st_v};
          bin_ff <= bin;
          state_ff <= ddf_pkg::S_WRITE;
        end
        ddf_pkg::S_WRITE: begin
          intcnt_ff <= nxt_int;
          sel_ff <= 1'b1;
          pend_ff <= !sel_ff;
          if (nxt_int == intlen_ff) begin
            dbin_ff <= '0;
            state_ff <= ddf_pkg::S_DUMP_RD;
          end else begin
            state_ff <= sel_ff ? ddf_pkg::S_COLLECT : ddf_pkg::S_READ;
          end
        end
        ddf_pkg::S_DUMP_RD: state_ff <= ddf_pkg::S_DUMP_WR;
        ddf_pkg::S_DUMP_WR: begin
          dbin_ff <= 11'(dbin_ff + 11'h001);
          state_ff <= ddf_pkg::S_DUMP_RD;
          if (last_bin) begin
            intcnt_ff <= 32'h0;
            state_ff <= pend_ff ? ddf_pkg::S_READ : ddf_pkg::S_COLLECT;
          end
        end
        default: state_ff <= ddf_pkg::S_COLLECT;
      endcase
    end
  end

  // Timing model: phase fraction advances by step, step by accel, once per sample
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      phase_ff <= 32'h0;
      step_ff <= 32'h0;
      tcnt_ff <= 16'h0;
      slot_ff <= '0;
    end else begin
      if (wr_en && (PADDR == `DDF_A_STEP)) begin
        step_ff <= PWDATA;
        phase_ff <= 32'h0;
      end else if (state_ff == ddf_pkg::S_WRITE) begin
        phase_ff <= phase_ff + step_ff;
        step_ff <= step_ff + accel_ff;
      end
      if (state_ff == ddf_pkg::S_DUMP_WR && last_bin) begin
        tcnt_ff <= 16'h0;
        slot_ff <= '0;
      end else if (state_ff == ddf_pkg::S_WRITE) begin
        tcnt_ff <= (tcnt_ff + 16'h1 >= tres_ff) ? 16'h0 : 16'(tcnt_ff + 16'h1);
        if (tcnt_ff + 16'h1 >= tres_ff) begin
          slot_ff <= (12'(slot_ff) + 12'h001 >= nbins_ff) ? '0 : 11'(slot_ff + 11'h001);
        end
      end
    end
  end

  // Memory word: I, Q, U, V, count from high to low
  assign mem_ra = (state_ff == ddf_pkg::S_READ) ? bin : dbin_ff;
  assign mem_we = (state_ff == ddf_pkg::S_WRITE) || (state_ff == ddf_pkg::S_DUMP_WR);
  assign mem_wa = (state_ff == ddf_pkg::S_WRITE) ? bin_ff : dbin_ff;
  assign mem_wd = (state_ff != ddf_pkg::S_WRITE) ? '0 : {
    32'(acc_rd[143:112] + stk_ff[0]), 32'(acc_rd[111:80] + stk_ff[1]),
    32'(acc_rd[79:48] + stk_ff[2]), 32'(acc_rd[47:16] + stk_ff[3]), 16'(acc_rd[15:0] + 16'h1)};
  ddf_bin_mem u_mem (
    .clk(SYS_CLK),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(mem_ra),
    .rdata(mem_rd)
  );
  // Bins not written since reset read as zero, so the first fold never adds unknown contents
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      bval_ff <= '0;
      bval_rd_ff <= 1'b0;
    end else begin
      bval_rd_ff <= bval_ff[mem_ra];
      if (mem_we) begin
        bval_ff[mem_wa] <= 1'b1;
      end
    end
  end
  assign acc_rd = bval_rd_ff ? mem_rd : '0;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      OUT_VALID <= 1'b0;
      OUT_LAST <= 1'b0;
      OUT_BIN <= '0;
      {OUT_I, OUT_Q, OUT_U, OUT_V, OUT_COUNT} <= '0;
    end else begin
      OUT_VALID <= state_ff == ddf_pkg::S_DUMP_WR;
      OUT_LAST <= (state_ff == ddf_pkg::S_DUMP_WR) && last_bin;
      if (state_ff == ddf_pkg::S_DUMP_WR) begin
        OUT_BIN <= dbin_ff;
        {OUT_I, OUT_Q, OUT_U, OUT_V, OUT_COUNT} <= acc_rd;
      end
    end
  end

  a_stokes_iq: assert property (st_i + st_q == 32'(px) <<< 1) else $error("I plus Q not twice X power");
  a_bin_range: assert property (state_ff == ddf_pkg::S_READ && !ctrl_ff[`DDF_CTRL_MODE]
    |-> 12'(bin) < nbins_ff) else $error("phase bin beyond bin count");
  a_count_incr: assert property (state_ff == ddf_pkg::S_WRITE
    |-> mem_wd[15:0] == 16'(acc_rd[15:0] + 16'h1)) else $error("bin counter not incremented");
  a_dump_zero: assert property (state_ff == ddf_pkg::S_DUMP_WR |-> mem_we && mem_wd == '0)
    else $error("bin not cleared on readout");
  a_dump_last: assert property ($fell(state_ff == ddf_pkg::S_DUMP_WR || state_ff == ddf_pkg::S_DUMP_RD)
    |-> OUT_LAST && OUT_BIN == 11'(nbins_ff - 12'h001)) else $error("readout ended early");
  a_hold_off: assert property (state_ff == ddf_pkg::S_DUMP_RD |-> !take ##1 !take)
    else $error("sample taken during readout");
  a_kernel_hold: assert property (!kern_stale && $stable(dm_ff) && $stable(ctrl_ff)
    |=> $stable(krot_ff[1]) && $stable(kwin_ff)) else $error("kernel changed without new config");
  a_block_seq: assert property (state_ff == ddf_pkg::S_BLOCK |=> state_ff == ddf_pkg::S_READ && !sel_ff
    ##1 state_ff == ddf_pkg::S_WRITE) else $error("block output sequence broken");
  a_slot_bin: assert property (state_ff == ddf_pkg::S_READ && ctrl_ff[`DDF_CTRL_MODE] |=> bin_ff == $past(slot_ff))
    else $error("transient bin not time slot");
  a_apb_ready: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("APB wait too long");
endmodule

// [shared/ddf_cfg.svh]
// Offsets, field positions, reset values and sizes of the dedisperse/detect/fold block.
// Included by the package and the design; holds definitions only.
`ifndef DDF_CFG_SVH
`define DDF_CFG_SVH
`define DDF_A_CTRL 8'h00
`define DDF_A_DM 8'h04
`define DDF_A_NBINS 8'h08
`define DDF_A_STEP 8'h0C
`define DDF_A_ACCEL 8'h10
`define DDF_A_INTLEN 8'h14
`define DDF_A_TRES 8'h18
`define DDF_A_STATUS 8'h1C
`define DDF_A_INTCNT 8'h20
`define DDF_CTRL_EN 0
`define DDF_CTRL_MODE 1
`define DDF_CTRL_WIN 2
`define DDF_RST_CTRL 3'h0
`define DDF_RST_NBINS 12'h800
`define DDF_RST_TRES 16'h0001
`define DDF_MAX_BINS 2048
`define DDF_BIN_W 11
`define DDF_FFT_LEN 4
`define DDF_DISCARD 2
`define DDF_ACC_W 32
`define DDF_CNT_W 16
`define DDF_ENTRY_W 144
`endif

// [shared/ddf_pkg.sv]
// Types shared by the dedisperse/detect/fold design files.
// Assumes ddf_cfg.svh is on the include path.
`include "ddf_cfg.svh"
package ddf_pkg;
  typedef enum logic [2:0] {
    S_COLLECT = 3'b000,
    S_BLOCK = 3'b001,
    S_READ = 3'b010,
    S_WRITE = 3'b011,
    S_DUMP_RD = 3'b100,
    S_DUMP_WR = 3'b101
  } ddf_state_e;
  typedef struct packed {
    logic signed [17:0] re;
    logic signed [17:0] im;
  } ddf_cx_s;
  typedef ddf_cx_s [3:0] ddf_cx4_t;
endpackage

// [rtl/ddf_bin_mem.sv]
// Phase-bin accumulator memory: one write port, one read port, registered read data.
// Assumes a single clock shared with the folding engine.
`timescale 1ns/1ps
`include "ddf_cfg.svh"
module ddf_bin_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [`DDF_BIN_W-1:0] waddr,
  input wire logic [`DDF_ENTRY_W-1:0] wdata,
  input wire logic [`DDF_BIN_W-1:0] raddr,
  output logic [`DDF_ENTRY_W-1:0] rdata
);
  logic [`DDF_ENTRY_W-1:0] mem [0:`DDF_MAX_BINS-1];
  // Contents are undefined until first written, by a fold update or by a readout clearing the bin
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// [bench/ddf_beam_src.sv]
// Upstream beam source model: offers dual-pol samples whose sign flips on every accepted sample.
// Assumes the block's registered ready and one clock; run starts the stream, slow adds gaps.
`timescale 1ns/1ps
module ddf_beam_src #(
  parameter logic signed [7:0] A_RE = 8'sh08,
  parameter logic signed [7:0] A_IM = 8'sh04,
  parameter logic signed [7:0] B_RE = 8'sh02,
  parameter logic signed [7:0] B_IM = 8'sh06
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic slow,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] x_re,
  output logic [7:0] x_im,
  output logic [7:0] y_re,
  output logic [7:0] y_im,
  output logic [15:0] taken
);
  logic valid_ff;
  logic neg_ff;
  logic gap_ff;
  logic [7:0] s_xr, s_xi, s_yr, s_yi;
  // Alternating sign keeps all energy in one FFT bin, so the window effect is exact
  assign s_xr = neg_ff ? -A_RE : A_RE;
  assign s_xi = neg_ff ? -A_IM : A_IM;
  assign s_yr = neg_ff ? -B_RE : B_RE;
  assign s_yi = neg_ff ? -B_IM : B_IM;
  // Lines show the inverse while no sample is offered, never a stale copy
  assign x_re = valid_ff ? s_xr : ~s_xr;
  assign x_im = valid_ff ? s_xi : ~s_xi;
  assign y_re = valid_ff ? s_yr : ~s_yr;
  assign y_im = valid_ff ? s_yi : ~s_yi;
  assign in_valid = valid_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_ff <= 1'b0;
      neg_ff <= 1'b0;
      gap_ff <= 1'b0;
      taken <= 16'h0000;
    end else begin
      if (valid_ff && in_ready) begin
        neg_ff <= ~neg_ff;
        taken <= taken + 16'h0001;
      end
      // An offered sample is held until taken
      if (!valid_ff || in_ready) begin
        valid_ff <= run && !(slow && gap_ff);
        gap_ff <= ~gap_ff;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench: APB register checks, input buffer refusal, fold and integrate readouts.
// Assumes ddf_cfg.svh on the include path and the beam source model in the same compile.
`timescale 1ns/1ps
`include "ddf_cfg.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, xr, xi, yr, yi;
  logic [31:0] pwdata, prdata, oi, oq, ou, ov;
  logic in_valid, in_ready, out_valid, out_last, run, slow;
  logic [10:0] out_bin;
  logic [15:0] ocnt, taken;
  logic [31:0] r_i[4], r_q[4], r_u[4], r_v[4];
  logic [15:0] r_c[4];
  logic [10:0] r_b[4];
  logic r_l[4];
  int idx, dumps, n_errors, compares;
  logic [31:0] rd;
  logic err;
  ddf_top DUT (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IN_VALID(in_valid), .IN_X_RE(xr), .IN_X_IM(xi), .IN_Y_RE(yr), .IN_Y_IM(yi), .IN_READY(in_ready),
    .OUT_VALID(out_valid), .OUT_LAST(out_last), .OUT_BIN(out_bin), .OUT_I(oi), .OUT_Q(oq),
    .OUT_U(ou), .OUT_V(ov), .OUT_COUNT(ocnt));
  ddf_beam_src SRC (.clk(sys_clk), .rst(reset), .run(run), .slow(slow), .in_ready(in_ready),
    .in_valid(in_valid), .x_re(xr), .x_im(xi), .y_re(yr), .y_im(yi), .taken(taken));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1) begin
      r_b[idx] = out_bin; r_c[idx] = ocnt; r_l[idx] = out_last;
      r_i[idx] = oi; r_q[idx] = oq; r_u[idx] = ou; r_v[idx] = ov;
      if (out_last === 1'b1) begin
        idx = 0;
        dumps++;
      end else if (idx < 3) begin
        idx++;
      end
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-drives PSEL in the same step
    @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("counts: compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Streams until two readouts are seen; the first holds the config transition and is dropped
  task automatic integrate(input logic sl);
    int t0;
    t0 = dumps;
    slow <= sl; run <= 1'b1;
    for (int n = 0; n < 6000 && dumps < t0 + 2; n++) @(posedge sys_clk);
    run <= 1'b0;
    if (dumps < t0 + 2) n_errors++;
  endtask
  task automatic chk_dump(input int cnt[4], input int si, input int sq, input int su, input int sv);
    for (int k = 0; k < 4; k++) begin
      `CHK("bin", k[10:0], r_b[k])
      `CHK("last", (k == 3), r_l[k])
      `CHK("count", cnt[k][15:0], r_c[k])
      `CHK("stokes_i", 32'(cnt[k] * si), r_i[k])
      `CHK("stokes_q", 32'(cnt[k] * sq), r_q[k])
      `CHK("stokes_u", 32'(cnt[k] * su), r_u[k])
      `CHK("stokes_v", 32'(cnt[k] * sv), r_v[k])
    end
  endtask
  task automatic t_regs;
    apb(0, `DDF_A_CTRL, 0);  `CHK("ctrl", 32'h0, rd)
    apb(0, `DDF_A_NBINS, 0); `CHK("nbins", 32'h800, rd)
    apb(0, `DDF_A_TRES, 0);  `CHK("tres", 32'h1, rd)
    apb(0, `DDF_A_INTLEN, 0); `CHK("intlen", 32'h0, rd)
    apb(1, `DDF_A_DM, 32'h5);
    apb(0, `DDF_A_DM, 0);    `CHK("dm", 32'h5, rd)
    apb(1, `DDF_A_ACCEL, 32'h12345678);
    apb(0, `DDF_A_ACCEL, 0); `CHK("accel", 32'h12345678, rd)
    apb(1, `DDF_A_ACCEL, 32'h0);
    apb(1, `DDF_A_INTCNT, 32'hFFFFFFFF);
    apb(0, `DDF_A_INTCNT, 0); `CHK("intcnt_ro", 32'h0, rd)
    apb(0, 8'h24, 0);        `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    $display("test regs done");
  endtask
  task automatic t_buffer;
    run <= 1'b1;
    repeat (12) @(posedge sys_clk);
    `CHK("taken_while_off", 16'h2, taken)
    `CHK("ready_full", 1'b0, in_ready)
    apb(0, `DDF_A_STATUS, 0);
    `CHK("status_full", 32'h10, rd)
    $display("test buffer done");
  endtask
  task automatic t_pulsar;
    apb(1, `DDF_A_NBINS, 32'h4);
    apb(1, `DDF_A_INTLEN, 32'h8);
    apb(1, `DDF_A_STEP, 32'h40000000);
    apb(1, `DDF_A_CTRL, 32'h1);
    integrate(1'b0);
    chk_dump('{2, 2, 2, 2}, 120, 40, 80, 80);
    apb(1, `DDF_A_STEP, 32'h0);
    integrate(1'b1);
    chk_dump('{8, 0, 0, 0}, 120, 40, 80, 80);
    $display("test pulsar done");
  endtask
  task automatic t_transient;
    apb(1, `DDF_A_TRES, 32'h4);
    apb(1, `DDF_A_CTRL, 32'h3);
    integrate(1'b0);
    chk_dump('{4, 4, 0, 0}, 120, 40, 80, 80);
    // Window on: FFT bin 2 is halved, so Stokes values are a quarter of those in pulsar mode
    apb(1, `DDF_A_TRES, 32'h1);
    apb(1, `DDF_A_CTRL, 32'h7);
    integrate(1'b0);
    chk_dump('{2, 2, 2, 2}, 30, 10, 20, 20);
    $display("test transient done");
  endtask
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    run = 1'b0; slow = 1'b0; idx = 0; dumps = 0; n_errors = 0; compares = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_buffer;
    t_pulsar;
    t_transient;
    wrap_up;
  end
  initial begin
    #500000;
    n_errors++;
    wrap_up;
  end
endmodule
